/* inc/msf_pkg.sv */
// constants for the mode select and fault log block
package msf_pkg;
    // register byte offsets (word index = byte offset, address = 4 * index)
    localparam logic [7:0] MSF_IDX_MODE     = 8'h70;
    localparam logic [7:0] MSF_IDX_FCODE_HI = 8'h80;
    localparam logic [7:0] MSF_IDX_FCODE_LO = 8'h81;
    localparam logic [7:0] MSF_IDX_FLAGS_HI = 8'h82;
    localparam logic [7:0] MSF_IDX_FLAGS_LO = 8'h83;
    localparam logic [7:0] MSF_IDX_PC_UP    = 8'h85;
    localparam logic [7:0] MSF_IDX_PC_MID   = 8'h86;
    localparam logic [7:0] MSF_IDX_PC_LOW   = 8'h87;
    localparam logic [7:0] MSF_IDX_IRQ_STAT = 8'h90;
    localparam logic [7:0] MSF_IDX_IRQ_MASK = 8'h91;
    // field positions
    localparam int MSF_MODE_BIT   = 7;
    localparam int MSF_USER_BIT   = 7;
    localparam int MSF_XMASK_BIT  = 6;
    localparam int MSF_IMASK_BIT  = 4;
    // reset values and patterns
    localparam logic [7:0]  MSF_BYTE_ZERO   = 8'h00;
    localparam logic [15:0] MSF_CODE_ZERO   = 16'h0000;
    localparam logic [15:0] MSF_CLEAR_PAT   = 16'hffff;
    localparam logic [23:0] MSF_PC_ZERO     = 24'h00_0000;
    localparam logic [31:0] MSF_WORD_ZERO   = 32'h0000_0000;
    // mode bit encodings: 1 normal single chip, 0 special single chip
    localparam logic MSF_MODE_NORMAL  = 1'b1;
    localparam logic MSF_MODE_SPECIAL = 1'b0;
    // irq status bits
    localparam int MSF_IRQ_FAULT  = 0;
    localparam int MSF_IRQ_MODE   = 1;
    // power modes
    typedef enum logic [1:0] {
        MSF_PWR_RUN  = 2'b00,
        MSF_PWR_WAIT = 2'b01,
        MSF_PWR_STOP = 2'b10
    } msf_pwr_t;
    // bus answer state
    typedef enum logic [0:0] {
        MSF_BUS_IDLE = 1'b0,
        MSF_BUS_DONE = 1'b1
    } msf_bus_t;
endpackage

/* hdl/msf_mode_fault.sv */
// mode select and fault log with avalon-mm register slave
// Operation
// RULE1 - the mode bit 7 is loaded from the boot config pin at reset release.
// RULE2 - only a write moving special to normal single chip mode is taken.
// RULE3 - the block works in run and wait and does no bus transfer in stop; a transfer taken just before stop still ends in the first stop cycle.
// RULE4 - reset is low active and its release edge samples the config pin.
// RULE5 - bits 7-4 of the high byte hold the initiator code.
// RULE6 - bits 3-0 of the high byte hold the target code.
// RULE7 - bits 7-4 of the low byte hold the access kind.
// RULE8 - bits 3-0 of the low byte hold the violation type.
// RULE9 - a core access violation loads a non-zero fault code.
// RULE10 - the pc and flag bits are captured in the same cycle as the code.
// RULE11 - a non-zero fault code blocks all further capture updates.
// RULE12 - writing all ones across both fault bytes clears them to zero.
// RULE13 - the captured pc is the address of the faulting instruction.
// RULE14 - user state, x mask and i mask are captured and read only.
// RULE15 - any other write to the fault bytes leaves the record unchanged.
`timescale 1ns/1ps
module msf_mode_fault
    import msf_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // pins
    input  wire logic        boot_config_pin,
    input  wire logic [1:0]  power_mode,
    // violation report from core side
    input  wire logic        fault_valid,
    input  wire logic [3:0]  fault_initiator_field,
    input  wire logic [3:0]  fault_target_field,
    input  wire logic [3:0]  fault_operation_kind,
    input  wire logic [3:0]  fault_type_field,
    input  wire logic [23:0] core_pc,
    input  wire logic        core_user_state,
    input  wire logic        core_x_mask,
    input  wire logic        core_i_mask,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // status
    output logic             mode_normal,
    output logic             irq
);

    logic [2:0]  cfg_sync_q;
    logic        cfg_level_q;
    logic        rst_seen_q;
    logic        mode_q;
    logic [7:0]  fcode_hi_q;
    logic [7:0]  fcode_lo_q;
    logic [23:0] pc_q;
    logic        user_q;
    logic        xmask_q;
    logic        imask_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_mask_q;
    logic [31:0] rdata_q;
    msf_bus_t    bus_q;
    logic        active;
    logic        req;
    logic        wr_go;
    logic        rd_go;
    logic [7:0]  idx;
    logic [7:0]  wbyte;
    logic        word_ok;
    logic        code_set;
    logic        capture;
    logic        mode_ok;
    logic        clr_hit;
    logic [31:0] rd_d;
    logic        rd_stat;
    logic [1:0]  irq_ev;

    assign active  = (power_mode != MSF_PWR_STOP);      // RULE3
    assign req     = (avs_read | avs_write) & active;   // RULE3
    assign idx     = avs_address[9:2];
    assign word_ok = (avs_address[1:0] == 2'b00);
    assign wbyte   = avs_writedata[7:0];
    assign wr_go   = avs_write & (bus_q == MSF_BUS_DONE) & avs_byteenable[0]
                     & word_ok;
    assign rd_go   = avs_read & (bus_q == MSF_BUS_DONE);
    assign avs_waitrequest = ~(bus_q == MSF_BUS_DONE);
    assign code_set = (fcode_hi_q != MSF_BYTE_ZERO)
                      | (fcode_lo_q != MSF_BYTE_ZERO);
    // core violations only, with a non-zero type
    assign capture = fault_valid & ~code_set & active
                     & (fault_initiator_field == 4'h1)
                     & (fault_type_field != 4'h0);           // RULE9 RULE11
    assign mode_ok = wr_go & (idx == MSF_IDX_MODE)
                     & (mode_q == MSF_MODE_SPECIAL)
                     & (wbyte[MSF_MODE_BIT] == MSF_MODE_NORMAL); // RULE2
    // all ones over both fault bytes: low half of the word, both lanes
    assign clr_hit = avs_write & (bus_q == MSF_BUS_DONE) & word_ok
                     & (idx == MSF_IDX_FCODE_HI)
                     & (avs_byteenable[1:0] == 2'b11)
                     & (avs_writedata[15:0] == MSF_CLEAR_PAT);  // RULE12 RULE15
    assign rd_stat = rd_go & word_ok & (idx == MSF_IDX_IRQ_STAT);
    assign irq_ev  = {mode_ok, capture};
    assign mode_normal = mode_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    // config pin synchroniser, change counts when stages two and three agree
    always_ff @(posedge mclk) begin
        cfg_sync_q <= {cfg_sync_q[1:0], boot_config_pin};
        if (cfg_sync_q[1] == cfg_sync_q[2]) begin
            cfg_level_q <= cfg_sync_q[2];
        end
    end

    // mode bit, taken at first clock after reset release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin                                   // RULE4
            rst_seen_q <= 1'b0;
            mode_q     <= MSF_MODE_SPECIAL;
        end else if (!rst_seen_q) begin
            rst_seen_q <= 1'b1;
            mode_q     <= cfg_level_q;                      // RULE1
        end else if (mode_ok) begin
            mode_q     <= MSF_MODE_NORMAL;                  // RULE2
        end
    end

    // fault record
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fcode_hi_q <= MSF_BYTE_ZERO;
            fcode_lo_q <= MSF_BYTE_ZERO;
        end else if (capture) begin
            fcode_hi_q <= {fault_initiator_field,
                           fault_target_field};             // RULE5 RULE6
            fcode_lo_q <= {fault_operation_kind,
                           fault_type_field};               // RULE7 RULE8
        end else if (clr_hit) begin
            fcode_hi_q <= MSF_BYTE_ZERO;                    // RULE12
            fcode_lo_q <= MSF_BYTE_ZERO;
        end
    end

    // pc and flag capture alongside the code
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pc_q    <= MSF_PC_ZERO;
            user_q  <= 1'b0;
            xmask_q <= 1'b0;
            imask_q <= 1'b0;
        end else if (capture) begin                         // RULE10 RULE11
            pc_q    <= core_pc;                             // RULE13
            user_q  <= core_user_state;                     // RULE14
            xmask_q <= core_x_mask;
            imask_q <= core_i_mask;
        end
    end

    // interrupt status, set wins over read clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_stat_q <= 2'b00;
            irq_mask_q <= 2'b00;
        end else begin
            irq_stat_q <= (rd_stat ? 2'b00 : irq_stat_q) | irq_ev;
            if (wr_go && idx == MSF_IDX_IRQ_MASK) begin
                irq_mask_q <= wbyte[1:0];
            end
        end
    end

    // read mux
    always_comb begin
        rd_d = MSF_WORD_ZERO;
        if (word_ok) begin
            unique case (idx)
                MSF_IDX_MODE:     rd_d[MSF_MODE_BIT] = mode_q;
                MSF_IDX_FCODE_HI: rd_d[7:0] = fcode_hi_q;
                MSF_IDX_FCODE_LO: rd_d[7:0] = fcode_lo_q;
                MSF_IDX_FLAGS_HI: rd_d[MSF_USER_BIT] = user_q;
                MSF_IDX_FLAGS_LO: begin
                    rd_d[MSF_XMASK_BIT] = xmask_q;
                    rd_d[MSF_IMASK_BIT] = imask_q;
                end
                MSF_IDX_PC_UP:    rd_d[7:0] = pc_q[23:16];
                MSF_IDX_PC_MID:   rd_d[7:0] = pc_q[15:8];
                MSF_IDX_PC_LOW:   rd_d[7:0] = pc_q[7:0];
                MSF_IDX_IRQ_STAT: rd_d[1:0] = irq_stat_q;
                MSF_IDX_IRQ_MASK: rd_d[1:0] = irq_mask_q;
                default:          rd_d = MSF_WORD_ZERO;
            endcase
        end
    end

    // bus answer: one wait cycle, held off in stop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_q   <= MSF_BUS_IDLE;
            rdata_q <= MSF_WORD_ZERO;
        end else begin
            unique case (bus_q)
                MSF_BUS_IDLE: begin
                    if (req) begin                          // RULE3
                        bus_q   <= MSF_BUS_DONE;
                        rdata_q <= rd_d;
                    end
                end
                MSF_BUS_DONE: begin
                    bus_q <= MSF_BUS_IDLE;
                end
            endcase
        end
    end

    assign avs_readdata = rdata_q;

endmodule

/* test/msf_mode_fault_sva.sv */
// assertion checker for the mode select and fault log block
`timescale 1ns/1ps
module msf_mf_sva
    import msf_pkg::*;
(
    // clock, reset, power
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [1:0]  power_mode,
    // register bus and status
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        mode_normal
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_take(a);
        avs_read && avs_waitrequest && power_mode != MSF_PWR_STOP
            && avs_address == a;
    endsequence
    AST_ANSWER: assert property (
        (avs_read || avs_write) && avs_waitrequest
        && power_mode != MSF_PWR_STOP |=> !avs_waitrequest)
        else $error("request not answered after one wait state");
    AST_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_STOP: assert property (
        power_mode == MSF_PWR_STOP && $past(power_mode) == MSF_PWR_STOP
        |-> avs_waitrequest)
        else $error("bus answered in stop");
    AST_HOLD: assert property (
        !$past(avs_read) && !$past(avs_write) |-> $stable(avs_readdata))
        else $error("read data changed without a request");
    AST_MODE_KEEP: assert property (mode_normal |=> mode_normal)
        else $error("mode left normal single chip");
    AST_MODE_SET: assert property (
        $rose(mode_normal) && $past(rst_n, 3) |-> $past(avs_write)
        && $past(avs_address) == {MSF_IDX_MODE, 2'b00}
        && $past(avs_writedata[7]))
        else $error("mode set without a mode write");
    AST_MODE_RD: assert property (
        s_take({MSF_IDX_MODE, 2'b00})
        |=> avs_readdata[7:0] == {mode_normal, 7'h00})
        else $error("mode read does not show the mode bit");
    AST_FLAGS_RD: assert property (
        s_take({MSF_IDX_FLAGS_LO, 2'b00}) |=> (avs_readdata[7:0] & 8'haf) == 0)
        else $error("unused flag bits read non-zero");
endmodule
bind msf_mode_fault msf_mf_sva u_msf_mf_sva (.mclk, .rst_n, .power_mode,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .mode_normal);

/* test/msf_core_model.sv */
// core side model that reports access violations
`timescale 1ns/1ps
module msf_core_model (
    // report request from the bench
    input  wire logic        go,
    input  wire logic [15:0] rec,
    input  wire logic [26:0] st,
    // violation report toward the block
    output logic             fault_valid,
    output logic      [3:0]  fault_initiator_field,
    output logic      [3:0]  fault_target_field,
    output logic      [3:0]  fault_operation_kind,
    output logic      [3:0]  fault_type_field,
    output logic      [23:0] core_pc,
    output logic             core_user_state,
    output logic             core_x_mask,
    output logic             core_i_mask
);
    // outside a report the fields carry the inverse, never stale values
    assign fault_valid = go;
    assign {fault_initiator_field, fault_target_field, fault_operation_kind,
        fault_type_field} = go ? rec : ~rec;
    assign {core_user_state, core_x_mask, core_i_mask, core_pc} =
        go ? st : ~st;
endmodule

/* test/msf_mode_fault_tb.sv */
// self-checking bench for the mode select and fault log block
`timescale 1ns/1ps
module msf_mode_fault_tb
    import msf_pkg::*;
;
    logic        mclk = 0, rst_n = 0, boot_config_pin = 1, go = 0;
    logic        avs_read = 0, avs_write = 0, avs_waitrequest, mode_normal;
    logic        irq, fault_valid, core_user_state, core_x_mask, core_i_mask;
    logic [1:0]  power_mode = MSF_PWR_RUN;
    logic [3:0]  avs_byteenable = 4'h3, fault_initiator_field;
    logic [3:0]  fault_target_field, fault_operation_kind, fault_type_field;
    logic [9:0]  avs_address = 0;
    logic [7:0]  ix [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h87};
    logic [15:0] rec = 0, r;
    logic [23:0] core_pc;
    logic [26:0] st = 0, s;
    logic [31:0] avs_writedata = 0, avs_readdata, q, seed = 80;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            results();
        end
    end
    msf_core_model u_msf_core_model (.go, .rec, .st, .fault_valid,
        .fault_initiator_field, .fault_target_field, .fault_operation_kind,
        .fault_type_field, .core_pc, .core_user_state, .core_x_mask,
        .core_i_mask);
    msf_mode_fault u_msf_mode_fault (.mclk, .rst_n, .boot_config_pin,
        .power_mode, .fault_valid, .fault_initiator_field, .fault_target_field,
        .fault_operation_kind, .fault_type_field, .core_pc, .core_user_state,
        .core_x_mask, .core_i_mask, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .mode_normal, .irq);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] ex(int j);
        case (j)
            0: return r[15:8];
            1: return r[7:0];
            2: return {s[26], 7'h00};
            3: return {1'b0, s[25], 1'b0, s[24], 4'h0};
            default: return s[8*(6-j) +: 8];
        endcase
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge mclk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= {i, 2'b00};
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        bus(1'b0, i, '0);
        chk($sformatf("reg %h", i), e, q[7:0]);
    endtask
    task automatic rep(input logic [15:0] rv, input logic [26:0] sv);
        @(posedge mclk);
        rec <= rv;
        st <= sv;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic rst(input logic p);
        @(posedge mclk);
        boot_config_pin <= p;
        rst_n <= 1'b0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst(1'b1);
        rc(MSF_IDX_MODE, 8'h80);
        bus(1'b1, MSF_IDX_MODE, '0);
        rc(MSF_IDX_MODE, 8'h80);
        rst(1'b0);
        rc(MSF_IDX_MODE, 8'h00);
        bus(1'b1, MSF_IDX_MODE, 32'h0000_007f);
        rc(MSF_IDX_MODE, 8'h00);
        bus(1'b1, MSF_IDX_MODE, 32'h0000_0080);
        rc(MSF_IDX_MODE, 8'h80);
        rc(8'h84, 8'h00);
        $display("test mode done");
        bus(1'b1, MSF_IDX_IRQ_MASK, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            r = {4'h1, 4'(rnd() % 5 + 1), 4'(rnd() % 4 + 1), 4'(rnd() % 2 + 1)};
            s = 27'(rnd());
            rep(r, s);
            chk("irq", 8'h01, {7'h00, irq});
            rep(r ^ 16'h0fff, ~s);
            bus(1'b1, MSF_IDX_FCODE_HI, 32'h0000_1234);
            for (int j = 0; j < 7; j++) begin
                rc(ix[j], ex(j));
            end
            bus(1'b0, MSF_IDX_IRQ_STAT, '0);
            chk("irq status", 8'h01, {7'h00, q[0]});
            bus(1'b1, MSF_IDX_FCODE_HI, 32'h0000_ffff);
            chk("irq clear", 8'h00, {7'h00, irq});
            rc(MSF_IDX_FCODE_HI, 8'h00);
            rc(MSF_IDX_FCODE_LO, 8'h00);
        end
        $display("test fault log done");
        rep({4'h3, r[11:0]}, s);
        rc(MSF_IDX_FCODE_HI, 8'h00);
        power_mode <= MSF_PWR_STOP;
        fork
            bus(1'b0, MSF_IDX_MODE, '0);
            begin
                rep(r, s);
                chk("stop wait", 8'h01, {7'h00, avs_waitrequest});
                @(posedge mclk);
                power_mode <= MSF_PWR_RUN;
            end
        join
        chk("stop read", 8'h80, q[7:0]);
        rc(MSF_IDX_FCODE_HI, 8'h00);
        $display("test stop done");
        results();
    end
endmodule
